// [verif/flash_id_and_bus_mode_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_id_and_bus_mode_control_tb;
    import fsid_pkg::*;
    logic        clk = 1'b0;
    logic        resetn, busy, qe, dpd_enter, cs_n, sck, quad, dpd, wake_rec, oe_seen, a0;
    logic [3:0]  host_io, io_o, io_oe;
    wire  [3:0]  io_w = (io_oe & io_o) | (~io_oe & host_io);
    logic [47:0] rx;
    logic [31:0] seed;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          n;

    always #50 clk = ~clk;
    always @(posedge clk) if (io_oe !== 4'h0) oe_seen <= 1'b1;

    fsid_cmd_ctrl u_fsid_cmd_ctrl (.clock_i(clk), .resetn_i(resetn), .cs_n_i(cs_n),
        .sck_i(sck), .io_i(io_w), .busy_i(busy), .quad_io_enable_bit_i(qe),
        .dpd_enter_i(dpd_enter), .io_o(io_o), .io_oe_o(io_oe),
        .quad_command_mode_o(quad), .deep_power_down_o(dpd), .wake_recovery_o(wake_rec));
    fsid_host_model u_fsid_host_model (.clock_i(clk), .dev_io_i(io_w), .cs_n_o(cs_n),
        .sck_o(sck), .io_o(host_io));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [47:0] pair_exp(input logic b);
        return b ? {16'h0, DEV_ID, MFR_ID, DEV_ID, MFR_ID} : {16'h0, MFR_ID, DEV_ID, MFR_ID, DEV_ID};
    endfunction

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic run(input logic [63:0] tx, input int ntx, input int ol, input int tl,
                       input int nrx, input int rl);
        oe_seen = 1'b0;
        u_fsid_host_model.xfer(tx, ntx, ol, tl, nrx, rl, rx);
    endtask

    task test_done;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        busy = 1'b0;
        qe = 1'b0;
        dpd_enter = 1'b0;
        seed = 32'd50251;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        check("mode_reset", quad, 48'h0);
        run({OPC_JEDEC, 56'h0}, 8, 1, 1, 48, 1);
        check("jedec_spi", rx, {2{MFR_ID, MEM_TYPE, CAPACITY}});
        for (int k = 0; k < 4; k++) begin
            a0 = rnd() & 1;
            run({OPC_MID, 23'h0, a0, 32'h0}, 32, 1, 1, 32, 1);
            check("mid_spi", rx, pair_exp(a0));
            run({OPC_MID_DUAL, 23'h0, a0, 8'(rnd()), 24'h0}, 40, 1, 2, 32, 2);
            check("mid_dual", rx, pair_exp(a0));
            run({OPC_MID_QUAD, 23'h0, a0, 8'(rnd()), 24'h0}, 56, 1, 4, 32, 4);
            check("mid_quad", rx, pair_exp(a0));
        end
        run({OPC_WAKE, 24'(rnd()), 32'h0}, 32, 1, 1, 16, 1);
        check("legacy_id", rx, {LEGACY_ID, LEGACY_ID});
        @(posedge clk) dpd_enter <= 1'b1;
        @(posedge clk) dpd_enter <= 1'b0;
        busy <= 1'b1;
        repeat (3) @(posedge clk);
        run({OPC_WAKE, 56'h0}, 8, 1, 1, 0, 1);
        check("wake_busy", {dpd, oe_seen}, 48'h2);
        busy <= 1'b0;
        run({OPC_JEDEC, 56'h0}, 8, 1, 1, 24, 1);
        check("dpd_other", {dpd, oe_seen}, 48'h2);
        run({OPC_WAKE, 56'h0}, 8, 1, 1, 0, 1);
        check("wake", {dpd, wake_rec}, 48'h1);
        for (n = 0; wake_rec && n < 100; n++) @(posedge clk);
        check("wake_end", wake_rec, 48'h0);
        run({OPC_QUAD_ON, 56'h0}, 8, 1, 1, 0, 1);
        check("quad_qe0", quad, 48'h0);
        qe <= 1'b1;
        run({OPC_QUAD_ON, 56'h0}, 1 + rnd() % 7, 1, 1, 0, 1);
        check("quad_short", quad, 48'h0);
        run({OPC_QUAD_ON, 56'h0}, 8, 1, 1, 0, 1);
        check("quad_on", quad, 48'h1);
        run({OPC_QUAD_OFF, 56'h0}, 4, 4, 4, 0, 4);
        check("off_short", quad, 48'h1);
        run({OPC_JEDEC, 56'h0}, 8, 4, 4, 48, 4);
        check("jedec_quad", rx, {2{MFR_ID, MEM_TYPE, CAPACITY}});
        run({OPC_MID, 23'h0, a0, 32'h0}, 32, 4, 4, 32, 4);
        check("mid_qpi", rx, pair_exp(a0));
        run({OPC_MID_DUAL, 56'h0}, 32, 4, 4, 16, 4);
        check("dual_qpi", oe_seen, 48'h0);
        run({OPC_WAKE, 56'h0}, 8, 4, 4, 16, 4);
        check("wake_quad", oe_seen, 48'h0);
        run({OPC_QUAD_OFF, 56'h0}, 8, 4, 4, 0, 4);
        check("quad_off", quad, 48'h0);
        test_done;
    end

    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        test_done;
    end
endmodule
`default_nettype wire

// [verif/fsid_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fsid_host_model (
    input  wire logic       clock_i,  // System clock
    input  wire logic [3:0] dev_io_i, // Resolved IO wire
    output logic            cs_n_o,   // Chip select, low
    output logic            sck_o,    // Serial clock
    output logic      [3:0] io_o      // Host IO drive
);
    // ****************************************************************
    // Frame driver
    // ****************************************************************
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        io_o   = 4'h0;
    end

    // Data set at the fall and held over the rise
    task automatic tick(input logic [3:0] d, output logic [3:0] r);
        sck_o <= 1'b0;
        io_o  <= d;
        repeat (4) @(posedge clock_i);
        sck_o <= 1'b1;
        repeat (4) @(posedge clock_i);
        r = dev_io_i;
    endtask

    task automatic xfer(input logic [63:0] tx, input int ntx, input int ol, input int tl,
                        input int nrx, input int rl, output logic [47:0] rx);
        logic [67:0] txp;
        logic [3:0]  r;
        int          l;
        txp = {tx, 4'h0};
        rx = '0;
        cs_n_o <= 1'b0;
        repeat (4) @(posedge clock_i);
        for (int i = 0; i < ntx; i += l) begin
            l = (i < 8) ? ol : tl;
            tick(txp[67-i -: 4] >> (4 - l), r);
        end
        // Released lines toggle so a stale level never reads as data
        for (int i = 0; i < nrx; i += rl) begin
            tick(~io_o, r);
            rx = (rl == 4) ? {rx[43:0], r} : (rl == 2) ? {rx[45:0], r[1:0]} : {rx[46:0], r[1]};
        end
        sck_o <= 1'b0;
        repeat (4) @(posedge clock_i);
        cs_n_o <= 1'b1;
        io_o   <= ~io_o;
        repeat (12) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// [verilog/fsid_cmd_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module fsid_cmd_ctrl
    import fsid_pkg::*;
(
    input  wire logic       clock_i,              // System clock, 10 MHz
    input  wire logic       resetn_i,             // Async reset, low
    input  wire logic       cs_n_i,               // Chip select pin, low
    input  wire logic       sck_i,                // Serial clock pin
    input  wire logic [3:0] io_i,                 // IO pins in
    input  wire logic       busy_i,               // Erase/program busy
    input  wire logic       quad_io_enable_bit_i, // Quad enable bit
    input  wire logic       dpd_enter_i,          // Power-down entry pulse
    output logic      [3:0] io_o,                 // IO pins out
    output logic      [3:0] io_oe_o,              // IO drive enables
    output logic            quad_command_mode_o,  // Quad command mode
    output logic            deep_power_down_o,    // In deep power-down
    output logic            wake_recovery_o       // Wake recovery running
);

    // ****************************************************************
    // Pin synchronisers and recovery timer
    // ****************************************************************
    fsid_pins_if pins ();

    fsid_pin_sync u_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .cs_n_i   (cs_n_i),
        .sck_i    (sck_i),
        .io_i     (io_i),
        .pins     (pins)
    );

    logic rec_start;

    fsid_recovery_timer u_timer (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .start_i  (rec_start),
        .busy_o   (wake_recovery_o)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] shift_in(input logic [31:0] s,
                                             input logic [3:0]  io,
                                             input logic [2:0]  ln);
        if (ln == LANE4) begin
            return {s[27:0], io};
        end else if (ln == LANE2) begin
            return {s[29:0], io[1:0]};
        end
        return {s[30:0], io[SI_BIT]};
    endfunction

    function automatic logic [2:0] addr_lanes(input logic [7:0] c, input logic q);
        if (c == OPC_MID_DUAL) begin
            return LANE2;
        end else if (c == OPC_MID_QUAD || q) begin
            return LANE4;
        end
        return LANE1;
    endfunction

    function automatic logic [4:0] addr_clk(input logic [7:0] c, input logic q);
        if (c == OPC_MID_DUAL) begin
            return ADDR_CLK_DUAL;
        end else if (c == OPC_MID_QUAD) begin
            return ADDR_CLK_QIO;
        end else if (q) begin
            return ADDR_CLK_QUAD;
        end
        return ADDR_CLK_SPI;
    endfunction

    function automatic logic [2:0] out_lanes(input logic [7:0] c, input logic q);
        if (c == OPC_MID_DUAL) begin
            return LANE2;
        end else if (c == OPC_MID_QUAD || q) begin
            return LANE4;
        end
        return LANE1;
    endfunction

    // Where the frame goes once the opcode is complete
    function automatic fsid_state_e decode(input logic [7:0] c, input logic q,
                                           input logic d, input logic b);
        if (d && c != OPC_WAKE) begin
            return ST_SKIP;
        end
        unique case (c)
            OPC_WAKE:     return (b || q) ? ST_SKIP : ST_DUMMY;
            OPC_MID:      return ST_ADDR;
            OPC_MID_DUAL: return q ? ST_SKIP : ST_ADDR;
            OPC_MID_QUAD: return q ? ST_SKIP : ST_ADDR;
            OPC_JEDEC:    return ST_OUT;
            default:      return ST_SKIP;
        endcase
    endfunction

    function automatic logic [7:0] id_byte(input logic [7:0] c, input logic [1:0] i);
        if (c == OPC_WAKE) begin
            return LEGACY_ID;
        end else if (c == OPC_JEDEC) begin
            return (i == 2'h0) ? MFR_ID : ((i == 2'h1) ? MEM_TYPE : CAPACITY);
        end
        return (i == 2'h0) ? MFR_ID : DEV_ID;
    endfunction

    function automatic logic [1:0] id_count(input logic [7:0] c);
        if (c == OPC_WAKE) begin
            return BYTES_WAKE;
        end else if (c == OPC_JEDEC) begin
            return BYTES_JEDEC;
        end
        return BYTES_MID;
    endfunction

    // ****************************************************************
    // Command state
    // ****************************************************************
    fsid_state_e st_q;
    logic [4:0]  cnt_q;
    logic [31:0] sh_q;
    logic [7:0]  cmd_q;
    logic [1:0]  start_q;
    logic        wake_pend_q;
    logic        mode_pend_q;
    logic        quad_q;
    logic        dpd_q;

    logic [2:0]  in_lanes;
    logic [31:0] sh_next;
    logic [7:0]  opc_next;
    logic [4:0]  cnt_inc;
    logic [4:0]  opc_clk;

    always_comb begin
        in_lanes = LANE1;
        if (st_q == ST_OPC) begin
            in_lanes = quad_q ? LANE4 : LANE1;
        end else if (st_q == ST_ADDR) begin
            in_lanes = addr_lanes(cmd_q, quad_q);
        end
    end

    assign sh_next  = shift_in(sh_q, pins.io, in_lanes);
    assign opc_next = sh_next[7:0];
    assign cnt_inc  = cnt_q + 5'h01;
    assign opc_clk  = quad_q ? OPC_CLK_QUAD : OPC_CLK_SPI;

    // Recovery blocks whole frames so a busy host sees no reply
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q        <= ST_OPC;
            cnt_q       <= 5'h00;
            sh_q        <= 32'h0000_0000;
            cmd_q       <= 8'h00;
            start_q     <= 2'h0;
            wake_pend_q <= 1'b0;
            mode_pend_q <= 1'b0;
        end else if (pins.cs_fall) begin
            st_q        <= wake_recovery_o ? ST_SKIP : ST_OPC;
            cnt_q       <= 5'h00;
            start_q     <= 2'h0;
            wake_pend_q <= 1'b0;
            mode_pend_q <= 1'b0;
        end else if (pins.sck_rise && !pins.cs_n) begin
            unique case (st_q)
                ST_OPC: begin
                    sh_q  <= sh_next;
                    cnt_q <= cnt_inc;
                    if (cnt_inc == opc_clk) begin
                        cmd_q <= opc_next;
                        cnt_q <= 5'h00;
                        st_q  <= decode(opc_next, quad_q, dpd_q, busy_i);
                        wake_pend_q <= (opc_next == OPC_WAKE) && !busy_i;
                        if (!dpd_q && opc_next == OPC_QUAD_ON) begin
                            mode_pend_q <= !quad_q && quad_io_enable_bit_i;
                        end
                        if (!dpd_q && opc_next == OPC_QUAD_OFF) begin
                            mode_pend_q <= quad_q;
                        end
                    end
                end
                ST_ADDR: begin
                    sh_q  <= sh_next;
                    cnt_q <= cnt_inc;
                    if (cnt_inc == addr_clk(cmd_q, quad_q)) begin
                        cnt_q <= 5'h00;
                        start_q <= {1'b0, (cmd_q == OPC_MID) ? sh_next[ADDR_LSB_PLAIN]
                                                             : sh_next[ADDR_LSB_MODE]};
                        st_q <= (cmd_q == OPC_MID_QUAD) ? ST_DUMMY : ST_OUT;
                    end
                end
                ST_DUMMY: begin
                    cnt_q <= cnt_inc;
                    if (cnt_inc == ((cmd_q == OPC_WAKE) ? DUMMY_CLK_WAKE
                                                        : DUMMY_CLK_QIO)) begin
                        cnt_q <= 5'h00;
                        st_q  <= ST_OUT;
                    end
                end
                ST_OUT: begin
                end
                ST_SKIP: begin
                end
                default: begin
                    st_q <= ST_SKIP;
                end
            endcase
        end
    end

    // ****************************************************************
    // Mode and power state
    // ****************************************************************
    // Only the lane mode flips here; the power-down flag and recovery
    // timer are never touched by a mode switch
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            quad_q <= 1'b0;
        end else if (pins.cs_rise && mode_pend_q) begin
            quad_q <= (cmd_q == OPC_QUAD_ON);
        end
    end

    assign rec_start = pins.cs_rise && wake_pend_q && dpd_q;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dpd_q <= 1'b0;
        end else if (dpd_enter_i) begin
            dpd_q <= 1'b1;
        end else if (rec_start) begin
            dpd_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            quad_command_mode_o <= 1'b0;
            deep_power_down_o   <= 1'b0;
        end else begin
            quad_command_mode_o <= quad_q;
            deep_power_down_o   <= dpd_q;
        end
    end

    // ****************************************************************
    // Reply shifter
    // ****************************************************************
    logic [2:0] pos_q;
    logic [1:0] idx_q;
    logic       begun_q;
    logic [1:0] cur_idx;
    logic [7:0] cur_byte;
    logic [7:0] cur_sh;
    logic [2:0] olanes;
    logic [3:0] pos_sum;

    assign cur_idx  = begun_q ? idx_q : start_q;
    assign cur_byte = id_byte(cmd_q, cur_idx);
    assign olanes   = out_lanes(cmd_q, quad_q);
    assign cur_sh   = cur_byte << pos_q;
    assign pos_sum  = {1'b0, pos_q} + {1'b0, olanes};

    // Data changes on the falling edge so the host samples it stable
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            io_o    <= 4'h0;
            io_oe_o <= 4'h0;
            pos_q   <= 3'h0;
            idx_q   <= 2'h0;
            begun_q <= 1'b0;
        end else if (pins.cs_fall || pins.cs_rise) begin
            io_oe_o <= 4'h0;
            pos_q   <= 3'h0;
            begun_q <= 1'b0;
        end else if (pins.sck_fall && !pins.cs_n && st_q == ST_OUT) begin
            begun_q <= 1'b1;
            pos_q   <= pos_sum[2:0];
            if (olanes == LANE4) begin
                io_o    <= cur_sh[7:4];
                io_oe_o <= OE_LANE4;
            end else if (olanes == LANE2) begin
                io_o    <= {2'h0, cur_sh[7:6]};
                io_oe_o <= OE_LANE2;
            end else begin
                io_o    <= {2'h0, cur_sh[7], 1'b0};
                io_oe_o <= OE_LANE1;
            end
            idx_q <= cur_idx;
            if (pos_sum[3]) begin
                idx_q <= (cur_idx + 2'h1 == id_count(cmd_q)) ? 2'h0
                                                            : cur_idx + 2'h1;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    quad_enter_cause_a: assert property ($rose(quad_q) |->
        $past(cmd_q) == OPC_QUAD_ON && $past(pins.cs_rise))
        else $error("quad mode entered without enable opcode");
    quad_needs_qe_a: assert property ($rose(quad_q) |->
        $past(quad_io_enable_bit_i, 2) && $past(mode_pend_q))
        else $error("quad mode entered without quad enable");
    quad_exit_cause_a: assert property ($fell(quad_q) |->
        $past(cmd_q) == OPC_QUAD_OFF && $past(mode_pend_q))
        else $error("quad mode left without disable opcode");
    mode_on_frame_a: assert property ($changed(quad_q) |-> $past(pins.cs_rise))
        else $error("mode changed outside frame end");
    legacy_spi_only_a: assert property ((st_q == ST_DUMMY && cmd_q == OPC_WAKE)
        |-> !quad_q)
        else $error("legacy ID path taken in quad mode");
    wake_not_busy_a: assert property ($rose(wake_pend_q) |-> !$past(busy_i))
        else $error("wake accepted while busy");
    pd_wake_only_a: assert property ((dpd_q && !pins.cs_n && !pins.cs_fall
        && st_q != ST_OPC && st_q != ST_SKIP) |-> cmd_q == OPC_WAKE)
        else $error("command accepted in power-down");
    wake_starts_rec_a: assert property ($fell(dpd_q) |-> wake_recovery_o)
        else $error("power-down left without recovery");
    rec_blocks_frame_a: assert property ((pins.cs_fall && wake_recovery_o) |=>
        st_q == ST_SKIP)
        else $error("frame accepted during recovery");
    drive_only_reply_a: assert property ((io_oe_o != 4'h0) |-> st_q == ST_OUT)
        else $error("IO driven outside reply");
    jedec_index_a: assert property ((cmd_q == OPC_JEDEC && begun_q) |->
        idx_q != 2'h3)
        else $error("standard ID index out of range");
    pair_index_a: assert property ((cmd_q == OPC_MID && begun_q) |->
        idx_q != 2'h2 && idx_q != 2'h3)
        else $error("ID pair index out of range");

endmodule
`default_nettype wire

// [verilog/fsid_pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module fsid_pin_sync (
    input  wire logic       clock_i,  // System clock
    input  wire logic       resetn_i, // Async reset, low
    input  wire logic       cs_n_i,   // Chip select pin
    input  wire logic       sck_i,    // Serial clock pin
    input  wire logic [3:0] io_i,     // IO pins
    fsid_pins_if.src        pins      // Synchronised view
);
    localparam logic [5:0] IDLE = 6'h01;

    logic [5:0] s1_q;
    logic [5:0] s2_q;
    logic [1:0] s3_q;

    // Stage one feeds stage two only
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_q <= IDLE;
            s2_q <= IDLE;
            s3_q <= IDLE[1:0];
        end else begin
            s1_q <= {io_i, sck_i, cs_n_i};
            s2_q <= s1_q;
            s3_q <= s2_q[1:0];
        end
    end

    assign pins.cs_n     = s2_q[0];
    assign pins.cs_rise  = s2_q[0] & ~s3_q[0];
    assign pins.cs_fall  = ~s2_q[0] & s3_q[0];
    assign pins.sck_rise = s2_q[1] & ~s3_q[1];
    assign pins.sck_fall = ~s2_q[1] & s3_q[1];
    assign pins.io       = s2_q[5:2];
endmodule
`default_nettype wire

// [verilog/fsid_pins_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface fsid_pins_if;
    logic       cs_n;
    logic       cs_rise;
    logic       cs_fall;
    logic       sck_rise;
    logic       sck_fall;
    logic [3:0] io;

    modport src (output cs_n, cs_rise, cs_fall, sck_rise, sck_fall, io);
    modport dst (input  cs_n, cs_rise, cs_fall, sck_rise, sck_fall, io);
endinterface
`default_nettype wire

// [verilog/fsid_pkg.sv]
package fsid_pkg;

    // ****************************************************************
    // Opcodes
    // ****************************************************************
    localparam logic [7:0] OPC_WAKE     = 8'hab;
    localparam logic [7:0] OPC_MID      = 8'h90;
    localparam logic [7:0] OPC_MID_DUAL = 8'h92;
    localparam logic [7:0] OPC_MID_QUAD = 8'h94;
    localparam logic [7:0] OPC_JEDEC    = 8'h9f;
    localparam logic [7:0] OPC_QUAD_ON  = 8'h38;
    localparam logic [7:0] OPC_QUAD_OFF = 8'hff;

    // ****************************************************************
    // Identity bytes, all values arbitrary
    // ****************************************************************
    localparam logic [7:0] MFR_ID    = 8'h5a;
    localparam logic [7:0] DEV_ID    = 8'h3c;
    localparam logic [7:0] LEGACY_ID = 8'h4e;
    localparam logic [7:0] MEM_TYPE  = 8'h66;
    localparam logic [7:0] CAPACITY  = 8'h21;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ           = 10;
    localparam int WAKE_RECOVERY_NS  = 3000;
    localparam int WAKE_CYC_RAW      = (WAKE_RECOVERY_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_RECOVERY_CYC = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;

    // ****************************************************************
    // Frame layout in serial clocks
    // ****************************************************************
    localparam logic [4:0] OPC_CLK_SPI    = 5'h08;
    localparam logic [4:0] OPC_CLK_QUAD   = 5'h02;
    localparam logic [4:0] ADDR_CLK_SPI   = 5'h18;
    localparam logic [4:0] ADDR_CLK_QUAD  = 5'h06;
    localparam logic [4:0] ADDR_CLK_DUAL  = 5'h10;
    localparam logic [4:0] ADDR_CLK_QIO   = 5'h08;
    localparam logic [4:0] DUMMY_CLK_QIO  = 5'h04;
    localparam logic [4:0] DUMMY_CLK_WAKE = 5'h18;
    localparam int         ADDR_LSB_PLAIN = 0;
    localparam int         ADDR_LSB_MODE  = 8;

    localparam logic [2:0] LANE1 = 3'h1;
    localparam logic [2:0] LANE2 = 3'h2;
    localparam logic [2:0] LANE4 = 3'h4;
    localparam int         SI_BIT = 0;

    localparam logic [3:0] OE_LANE1 = 4'h2;
    localparam logic [3:0] OE_LANE2 = 4'h3;
    localparam logic [3:0] OE_LANE4 = 4'hf;

    localparam logic [1:0] BYTES_WAKE  = 2'h1;
    localparam logic [1:0] BYTES_MID   = 2'h2;
    localparam logic [1:0] BYTES_JEDEC = 2'h3;

    typedef enum logic [2:0] {
        ST_OPC   = 3'b000,
        ST_ADDR  = 3'b001,
        ST_DUMMY = 3'b010,
        ST_OUT   = 3'b011,
        ST_SKIP  = 3'b100
    } fsid_state_e;

endpackage

// [verilog/fsid_recovery_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module fsid_recovery_timer
    import fsid_pkg::*;
(
    input  wire logic clock_i,  // System clock
    input  wire logic resetn_i, // Async reset, low
    input  wire logic start_i,  // Start pulse
    output logic      busy_o    // Recovery running
);
    localparam logic [7:0] CNT_LOAD = 8'(WAKE_RECOVERY_CYC);
    localparam logic [7:0] CNT_ONE  = 8'h01;

    logic [7:0] cnt_q;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q  <= 8'h00;
            busy_o <= 1'b0;
        end else if (start_i) begin
            cnt_q  <= CNT_LOAD;
            busy_o <= 1'b1;
        end else if (busy_o) begin
            cnt_q  <= cnt_q - CNT_ONE;
            busy_o <= (cnt_q != CNT_ONE);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    rec_min_len_a: assert property ($rose(busy_o) |-> busy_o [*8])
        else $error("wake recovery ended early");
    rec_end_a: assert property ($fell(busy_o) |-> $past(cnt_q) == CNT_ONE)
        else $error("wake recovery end not at count");
endmodule
`default_nettype wire
